// ---- stc_cfg.svh ----
// Constants for the servo test-mode command handler
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ==========================================
// Link commands and data numbers
`define STC_CMD_READ_MODE 8'h00
`define STC_CMD_POS 8'h40
`define STC_CMD_SPD 8'h50
`define STC_CMD_ACC 8'h54
`define STC_CMD_DEC 8'h58
`define STC_CMD_MODE 8'h8B
`define STC_CMD_IMAGE 8'h92
`define STC_NO_MODE_SET 8'h00
`define STC_NO_MODE_RD 8'h12
`define STC_NO_IMG_LAST 8'h02
`define STC_NO_OUT_IMG 8'hA0
`define STC_NO_PT_MIN 8'h01
`define STC_NO_PT_MAX 8'h1F

// ==========================================
// Test operation mode codes
`define STC_MODE_NORMAL 3'h0
`define STC_MODE_MAX 3'h5
`define STC_MODE_FORCE 3'h4
`define STC_MODE_STEP 3'h5
`define STC_SET_CANCEL 32'h0000_0000
`define STC_SET_FORCE 32'h0000_0004
`define STC_SET_STEP 32'h0000_0005

// ==========================================
// Input image bit positions
`define STC_B_SON 0
`define STC_B_FSE 1
`define STC_B_RSE 2
`define STC_B_TSTOP 24
`define STC_B_MSEL 0
`define STC_B_DOG 9

// ==========================================
// Register map (byte addresses) and fields
`define STC_REG_MODE 10'h000
`define STC_REG_IMG0 10'h004
`define STC_REG_IMG1 10'h008
`define STC_REG_IMG2 10'h00C
`define STC_REG_OUT 10'h010
`define STC_REG_STAT 10'h014
`define STC_REG_CTRL 10'h018
// Point table fills the upper half: index addr[8:4], field addr[3:2]
// Page bit must not overlap the index, or indexes 0..15 go unreachable
`define STC_PT_PAGE 9:9
`define STC_PT_SEL 1'h1
`define STC_PT_IDX 8:4
`define STC_PT_FLD 3:2
`define STC_CTRL_RST 1'h1

// ==========================================
// Communication-loss time
`define STC_LOSS_TIME_MS 500
`define STC_CLK_KHZ 125000

`endif

// ---- stc_pkg.sv ----
// Types shared by the servo test-mode command handler
package stc_pkg;

	// ==========================================
	// Answer to a link command
	typedef enum logic [2:0] {
		STC_RSP_OK,
		STC_RSP_BAD_CMD,
		STC_RSP_BAD_NO,
		STC_RSP_BAD_DATA,
		STC_RSP_BAD_MODE
	} stc_rsp_type;

	// Test operation mode code
	typedef logic [2:0] stc_mode_type;

endpackage : stc_pkg

// ---- stc_handler.sv ----
// Test-mode command interpreter of the servo amplifier slave
`timescale 1ns/1ps
`include "stc_cfg.svh"

// Function
// - Command 92, number 00..02 loads a 32-bit input image, one means on.
// - Image bits drive servo-on, stroke ends, temporary stop, mode select, dog.
// - Setting and reply words travel as eight hexadecimal characters.
// - In test mode, 0.5 s without a frame decelerates to servo-lock.
// - Entering test mode by command 8B while running shuts off the base circuit.
// - Command 8B number 00: 0004 forced output, 0005 single-step feed.
// - Command 00 number 12 returns the current test mode code.
// - Mode codes: 0 normal, 1 jog, 2 positioning, 3 motor-less, 4, 5.
// - Command 8B number 00 data 0000 cancels test mode and forced output.
// - In forced mode, 92/A0 drives output pins 0,1,2,5,6 from the image.
// - Command 40 number 01..1F returns that point table's position.
// - Commands 50, 54, 58 return speed, acceleration, deceleration entries.
// - Device states follow only the latest image; no bits are kept.
module stc_handler #(
	parameter int LOSS_CYCLES = `STC_LOSS_TIME_MS * `STC_CLK_KHZ,
	parameter int LOSS_W = 27
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Decoded frame from the link
	input wire logic i_frm_valid,
	input wire logic [7:0] i_frm_cmd,
	input wire logic [7:0] i_frm_no,
	input wire logic [63:0] i_frm_data,
	// Answer to the link
	output logic o_rsp_valid,
	output stc_pkg::stc_rsp_type o_rsp_code,
	output logic [31:0] o_rsp_data,
	output logic [63:0] o_rsp_hex,
	// Drive status
	input wire logic i_motor_running,
	input wire logic i_home_return_complete,
	// Register port
	input wire logic [9:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Test input devices
	output logic o_servo_on_input,
	output logic o_forward_stroke_end,
	output logic o_reverse_stroke_end,
	output logic o_temporary_stop_input,
	output logic o_operation_mode_select,
	output logic o_proximity_dog_input,
	// Drive actions and forced outputs
	output logic o_base_off,
	output logic o_decel_stop,
	output logic o_test_active,
	output logic o_do_force_en,
	output logic [4:0] o_do_force
);
	import stc_pkg::*;

	// ==========================================
	// Functions
	// One ASCII hex digit; bit 4 flags a valid digit
	function automatic logic [4:0] asc_to_nib(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
			r = {1'b1, c[3:0]};
		else if (c >= 8'h41 && c <= 8'h46)
			r = {1'b1, c[3:0] + 4'h9};
		return r;
	endfunction : asc_to_nib

	// Eight characters, first one most significant
	function automatic logic [32:0] hex_to_word(input logic [63:0] h);
		logic [32:0] r;
		logic [4:0] n;
		r = {1'b1, 32'h0000_0000};
		for (int i = 0; i < 8; i++)
		begin
			n = asc_to_nib(h[i*8 +: 8]);
			r[i*4 +: 4] = n[3:0];
			r[32] = r[32] & n[4];
		end
		return r;
	endfunction : hex_to_word

	function automatic logic [7:0] nib_to_asc(input logic [3:0] n);
		return (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
	endfunction : nib_to_asc

	function automatic logic [63:0] word_to_hex(input logic [31:0] w);
		logic [63:0] r;
		r = 64'h0;
		for (int i = 0; i < 8; i++)
			r[i*8 +: 8] = nib_to_asc(w[i*4 +: 4]);
		return r;
	endfunction : word_to_hex

	// ==========================================
	// State
	stc_mode_type mode;
	logic [31:0] img [0:2];
	logic [31:0] out_img;
	logic [31:0] pt_mem [0:31][0:3];
	logic [LOSS_W-1:0] loss_cnt;
	logic link_en;

	// ==========================================
	// Frame decode
	logic take;
	logic [32:0] frm_hex;
	logic [31:0] frm_word;
	logic dec_img;
	logic dec_out;
	logic dec_mode;
	logic [1:0] pt_fld;
	logic pt_no_ok;
	stc_rsp_type next_code;
	logic [31:0] next_data;

	assign take = i_ce && i_frm_valid && link_en;
	assign frm_hex = hex_to_word(i_frm_data);
	assign frm_word = frm_hex[31:0];
	assign pt_no_ok = i_frm_no >= `STC_NO_PT_MIN &&
		i_frm_no <= `STC_NO_PT_MAX;

	// Sort each frame into one action and an answer
	always_comb
	begin
		next_code = STC_RSP_OK;
		next_data = 32'h0000_0000;
		dec_img = 1'b0;
		dec_out = 1'b0;
		dec_mode = 1'b0;
		pt_fld = 2'h0;
		case (i_frm_cmd)
			`STC_CMD_IMAGE:
			begin
				if (!frm_hex[32])
					next_code = STC_RSP_BAD_DATA;
				else if (i_frm_no <= `STC_NO_IMG_LAST)
					dec_img = 1'b1;
				else if (i_frm_no != `STC_NO_OUT_IMG)
					next_code = STC_RSP_BAD_NO;
				else if (mode == `STC_MODE_FORCE)
					dec_out = 1'b1;
				else
					next_code = STC_RSP_BAD_MODE;
			end
			`STC_CMD_MODE:
			begin
				if (i_frm_no != `STC_NO_MODE_SET)
					next_code = STC_RSP_BAD_NO;
				else if (frm_hex[32] && (frm_word == `STC_SET_CANCEL ||
					frm_word == `STC_SET_FORCE ||
					frm_word == `STC_SET_STEP))
					dec_mode = 1'b1;
				else
					next_code = STC_RSP_BAD_DATA;
			end
			`STC_CMD_READ_MODE:
			begin
				if (i_frm_no == `STC_NO_MODE_RD)
					next_data = {29'h0, mode};
				else
					next_code = STC_RSP_BAD_NO;
			end
			`STC_CMD_POS, `STC_CMD_SPD, `STC_CMD_ACC, `STC_CMD_DEC:
			begin
				// position is field 0, the others follow it
				pt_fld = (i_frm_cmd == `STC_CMD_POS) ? 2'h0 :
					i_frm_cmd[3:2] + 2'h1;
				if (!pt_no_ok)
					next_code = STC_RSP_BAD_NO;
				else
					next_data = pt_mem[i_frm_no[4:0]][pt_fld];
			end
			default:
				next_code = STC_RSP_BAD_CMD;
		endcase
	end

	// ==========================================
	// Answer, one cycle after the frame
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_rsp_valid <= 1'b0;
			o_rsp_code <= STC_RSP_OK;
			o_rsp_data <= 32'h0000_0000;
			o_rsp_hex <= 64'h0;
		end
		else if (i_ce)
		begin
			o_rsp_valid <= take;
			if (take)
			begin
				o_rsp_code <= next_code;
				o_rsp_data <= next_data;
				o_rsp_hex <= word_to_hex(next_data);
			end
		end
	end

	// ==========================================
	// Test mode; a link write wins over a register write
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			mode <= `STC_MODE_NORMAL;
		else if (i_ce)
		begin
			if (take && dec_mode)
				mode <= frm_word[2:0];
			else if (i_wr && i_addr == `STC_REG_MODE &&
				i_wdata[2:0] <= `STC_MODE_MAX)
				mode <= i_wdata[2:0];
		end
	end

	assign o_test_active = mode != `STC_MODE_NORMAL;

	// ==========================================
	// Input and output images, replaced whole
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			img[0] <= 32'h0000_0000;
			img[1] <= 32'h0000_0000;
			img[2] <= 32'h0000_0000;
			out_img <= 32'h0000_0000;
		end
		else if (i_ce)
		begin
			if (take && dec_img)
				img[i_frm_no[1:0]] <= frm_word;
			if (take && dec_out)
				out_img <= frm_word;
			else if (take && dec_mode && frm_word == `STC_SET_CANCEL)
				out_img <= 32'h0000_0000;
		end
	end

	assign o_servo_on_input = o_test_active && img[0][`STC_B_SON];
	assign o_forward_stroke_end = o_test_active && img[0][`STC_B_FSE];
	assign o_reverse_stroke_end = o_test_active && img[0][`STC_B_RSE];
	assign o_temporary_stop_input = o_test_active &&
		img[0][`STC_B_TSTOP];
	assign o_operation_mode_select = o_test_active &&
		img[2][`STC_B_MSEL];
	assign o_proximity_dog_input = o_test_active && img[2][`STC_B_DOG];

	// physical pins regardless of servo status
	assign o_do_force_en = mode == `STC_MODE_FORCE;
	assign o_do_force = o_do_force_en ?
		{out_img[6:5], out_img[2:0]} : 5'h00;

	// ==========================================
	// Communication-loss timer and stop latch
	logic loss_hit;
	assign loss_hit = o_test_active && !take &&
		loss_cnt == LOSS_W'(LOSS_CYCLES - 1);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			loss_cnt <= '0;
		else if (i_ce)
		begin
			// restart on frame, idle when normal
			if (!o_test_active || take)
				loss_cnt <= '0;
			else if (loss_cnt != LOSS_W'(LOSS_CYCLES))
				loss_cnt <= loss_cnt + 1'b1;
		end
	end

	// Stop holds after frames resume; servo-lock must be released on purpose
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_decel_stop <= 1'b0;
		else if (i_ce)
		begin
			if (loss_hit)
				o_decel_stop <= 1'b1;
			else if (!o_test_active ||
				(i_wr && i_addr == `STC_REG_CTRL && i_wdata[1]))
				o_decel_stop <= 1'b0;
		end
	end

	// Base stays off until software clears it or power cycles
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_base_off <= 1'b0;
		else if (i_ce)
		begin
			if (take && dec_mode && !o_test_active &&
				frm_word != `STC_SET_CANCEL && i_motor_running)
				o_base_off <= 1'b1;
			else if (i_wr && i_addr == `STC_REG_CTRL && i_wdata[2])
				o_base_off <= 1'b0;
		end
	end

	// ==========================================
	// Register port: control and point tables
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			link_en <= `STC_CTRL_RST;
		else if (i_ce && i_wr && i_addr == `STC_REG_CTRL)
			link_en <= i_wdata[0];
	end

	// Table has no reset; software loads it before use
	always_ff @(posedge i_clk)
	begin
		if (i_ce && i_wr && i_addr[`STC_PT_PAGE] == `STC_PT_SEL)
			pt_mem[i_addr[`STC_PT_IDX]][i_addr[`STC_PT_FLD]] <= i_wdata;
	end

	// Read data stand one cycle only; unmapped reads zero
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= 32'h0000_0000;
		else if (i_ce)
		begin
			o_rdata <= 32'h0000_0000;
			if (i_rd)
			begin
				if (i_addr[`STC_PT_PAGE] == `STC_PT_SEL)
					o_rdata <= pt_mem[i_addr[`STC_PT_IDX]][i_addr[`STC_PT_FLD]];
				else
					case (i_addr)
						`STC_REG_MODE: o_rdata <= {29'h0, mode};
						`STC_REG_IMG0: o_rdata <= img[0];
						`STC_REG_IMG1: o_rdata <= img[1];
						`STC_REG_IMG2: o_rdata <= img[2];
						`STC_REG_OUT: o_rdata <= out_img;
						`STC_REG_STAT: o_rdata <= {28'h0,
							i_home_return_complete, o_do_force_en,
							o_base_off, o_decel_stop};
						`STC_REG_CTRL: o_rdata <= {31'h0, link_en};
						default: o_rdata <= 32'h0000_0000;
					endcase
			end
		end
	end

	// ==========================================
	// Checks
	// image load
	AST_IMG_LOAD: assert property (@(posedge i_clk) disable iff (i_rst)
		take && dec_img && i_frm_no == 8'h00 |=> img[0] == $past(frm_word))
		else $error("input image word 0 not loaded");

	AST_SON_MAP: assert property (@(posedge i_clk) disable iff (i_rst)
		o_servo_on_input |-> o_test_active && img[0][`STC_B_SON])
		else $error("servo-on driven outside test mode");

	AST_HEX_RSP: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rsp_valid |-> o_rsp_hex == word_to_hex(o_rsp_data))
		else $error("reply characters do not match reply word");

	AST_LOSS_STOP: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && loss_hit |=> o_decel_stop)
		else $error("loss stop not raised");

	AST_BASE_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
		take && dec_mode && !o_test_active && i_motor_running &&
		frm_word == `STC_SET_STEP |=> o_base_off && mode == `STC_MODE_STEP)
		else $error("base not shut off on entering test mode");

	AST_MODE_READ: assert property (@(posedge i_clk) disable iff (i_rst)
		take && i_frm_cmd == `STC_CMD_READ_MODE &&
		i_frm_no == `STC_NO_MODE_RD |=>
		o_rsp_valid && o_rsp_data == {29'h0, $past(mode)})
		else $error("mode read-back wrong");

	AST_CANCEL: assert property (@(posedge i_clk) disable iff (i_rst)
		take && dec_mode && frm_word == `STC_SET_CANCEL |=>
		!o_test_active && !o_do_force_en && out_img == 32'h0)
		else $error("cancel left test mode active");

	AST_FORCE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_do_force != 5'h00 |-> mode == `STC_MODE_FORCE &&
		o_do_force == {out_img[6:5], out_img[2:0]})
		else $error("forced pins wrong");

	AST_PT_READ: assert property (@(posedge i_clk) disable iff (i_rst)
		take && i_frm_cmd == `STC_CMD_POS && pt_no_ok |=>
		o_rsp_code == STC_RSP_OK &&
		o_rsp_data == $past(pt_mem[i_frm_no[4:0]][0]))
		else $error("point table position read wrong");

	AST_TIMER_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && (!o_test_active || take) |=> loss_cnt == '0)
		else $error("loss timer not restarted");

endmodule : stc_handler

// ---- stc_master_model.sv ----
// Master station model that hands decoded frames to the handler
`timescale 1ns/1ps
module stc_master_model (
	// Clock
	input wire logic i_clk,
	// Decoded frame toward the handler
	output logic o_frm_valid,
	output logic [7:0] o_frm_cmd,
	output logic [7:0] o_frm_no,
	output logic [63:0] o_frm_data
);
	// ==========================================
	// Encoding
	// word as hex characters
	function automatic logic [63:0] to_hex(input logic [31:0] w);
		logic [63:0] h;
		logic [3:0] n;
		h = '0;
		for (int i = 0; i < 8; i++)
		begin
			n = w[4*i +: 4];
			h[8*i +: 8] = (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
		end
		return h;
	endfunction : to_hex

	// ==========================================
	// Frames
	// the bench orders the frames
	// Data lines invert once released so stale values are never reused
	task automatic send(input logic [7:0] c, input logic [7:0] no,
		input logic [31:0] w);
		@(posedge i_clk);
		o_frm_valid <= 1'b1;
		o_frm_cmd <= c;
		o_frm_no <= no;
		o_frm_data <= to_hex(w);
		@(posedge i_clk);
		o_frm_valid <= 1'b0;
		o_frm_data <= ~to_hex(w);
	endtask : send

	// Idle at time zero
	initial
	begin
		o_frm_valid = 1'b0;
		o_frm_cmd = 8'h00;
		o_frm_no = 8'h00;
		o_frm_data = '0;
	end
endmodule : stc_master_model

// ---- stc_handler_tb_top.sv ----
// Self-checking bench of the servo test-mode command handler
`timescale 1ns/1ps
`include "stc_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module stc_handler_tb_top;
	import stc_pkg::*;
	localparam int LOSS = 20;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_mr = 1'b0;
	logic i_hrc = 1'b0;
	logic [9:0] i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic fv;
	logic [7:0] fc, fn;
	logic [63:0] fd, o_rsp_hex;
	logic o_rsp_valid, o_son, o_fse, o_rse, o_tst, o_msel, o_dog;
	stc_rsp_type o_rsp_code;
	logic [31:0] o_rsp_data, o_rdata, d;
	logic o_base_off, o_decel_stop, o_test_active, o_do_force_en;
	logic [4:0] o_do_force;
	int err_count = 0;
	int n_checks = 0;
	logic [7:0] tcmd [4] = '{`STC_CMD_POS, `STC_CMD_SPD, `STC_CMD_ACC,
		`STC_CMD_DEC};

	// ==========================================
	// Clock and parts
	always #4 i_clk = ~i_clk;
	stc_master_model u_stc_master_model (.i_clk(i_clk), .o_frm_valid(fv),
		.o_frm_cmd(fc), .o_frm_no(fn), .o_frm_data(fd));
	stc_handler #(.LOSS_CYCLES(LOSS)) u_stc_handler (.i_clk(i_clk),
		.i_rst(i_rst), .i_ce(1'b1), .i_frm_valid(fv), .i_frm_cmd(fc),
		.i_frm_no(fn), .i_frm_data(fd), .o_rsp_valid(o_rsp_valid),
		.o_rsp_code(o_rsp_code), .o_rsp_data(o_rsp_data),
		.o_rsp_hex(o_rsp_hex), .i_motor_running(i_mr),
		.i_home_return_complete(i_hrc), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_servo_on_input(o_son), .o_forward_stroke_end(o_fse),
		.o_reverse_stroke_end(o_rse), .o_temporary_stop_input(o_tst),
		.o_operation_mode_select(o_msel), .o_proximity_dog_input(o_dog),
		.o_base_off(o_base_off), .o_decel_stop(o_decel_stop),
		.o_test_active(o_test_active), .o_do_force_en(o_do_force_en),
		.o_do_force(o_do_force));

	// ==========================================
	// Access tasks
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask : rd

	// One frame, answer checked in its single valid cycle
	task automatic link(input logic [7:0] c, input logic [7:0] no,
		input logic [31:0] w, input stc_rsp_type rc, input logic [31:0] e);
		u_stc_master_model.send(c, no, w);
		#1;
		`CHK("rsp_valid", 1'b1, o_rsp_valid)
		`CHK("rsp_code", rc, o_rsp_code)
		`CHK("rsp_data", e, o_rsp_data)
		`CHK("rsp_hex", u_stc_master_model.to_hex(e), o_rsp_hex)
	endtask : link

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	// ==========================================
	// Watchdog, far beyond the expected run of about 180 cycles
	initial
	begin
		#50000;
		err_count++;
		end_of_test();
	end

	// ==========================================
	// Tests
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(`STC_REG_CTRL, d);
		`CHK("ctrl reset", 32'h0000_0001, d)
		link(`STC_CMD_READ_MODE, `STC_NO_MODE_RD, 0, STC_RSP_OK, 0);
		link(`STC_CMD_IMAGE, 8'h00, 32'h0100_0007, STC_RSP_OK, 0);
		`CHK("gated", 1'b0, o_son)
		$display("test reset and normal mode done");
		// Home return is confirmed before stepping starts
		@(posedge i_clk);
		i_hrc <= 1'b1;
		i_mr <= 1'b1;
		rd(`STC_REG_STAT, d);
		`CHK("home", 4'h8, d[3:0])
		link(`STC_CMD_MODE, 8'h00, `STC_SET_STEP, STC_RSP_OK, 0);
		`CHK("base_off", 1'b1, o_base_off)
		`CHK("test_active", 1'b1, o_test_active)
		`CHK("img0", 4'hF, {o_son, o_fse, o_rse, o_tst})
		link(`STC_CMD_IMAGE, 8'h02, 32'h0000_0201, STC_RSP_OK, 0);
		`CHK("img2", 2'b11, {o_msel, o_dog})
		link(`STC_CMD_IMAGE, 8'h00, 32'h0100_0002, STC_RSP_OK, 0);
		`CHK("img0 new", 4'h5, {o_son, o_fse, o_rse, o_tst})
		link(`STC_CMD_READ_MODE, `STC_NO_MODE_RD, 0, STC_RSP_OK, 5);
		$display("test step mode and inputs done");
		link(`STC_CMD_IMAGE, `STC_NO_OUT_IMG, 1, STC_RSP_BAD_MODE, 0);
		`CHK("no force", 5'h00, o_do_force)
		link(8'h90, 8'h00, 0, STC_RSP_BAD_CMD, 0);
		link(`STC_CMD_MODE, 8'h00, `STC_SET_FORCE, STC_RSP_OK, 0);
		`CHK("force_en", 1'b1, o_do_force_en)
		link(`STC_CMD_IMAGE, `STC_NO_OUT_IMG, 32'hFFFF_FF25,
			STC_RSP_OK, 0);
		`CHK("do_force", 5'h0D, o_do_force)
		link(`STC_CMD_READ_MODE, `STC_NO_MODE_RD, 0, STC_RSP_OK, 4);
		$display("test forced output done");
		// A frame just inside the limit restarts the count
		repeat (LOSS - 5) @(posedge i_clk);
		link(`STC_CMD_READ_MODE, `STC_NO_MODE_RD, 0, STC_RSP_OK, 4);
		`CHK("decel early", 1'b0, o_decel_stop)
		repeat (LOSS + 2) @(posedge i_clk);
		#1;
		`CHK("decel", 1'b1, o_decel_stop)
		link(`STC_CMD_MODE, 8'h00, `STC_SET_CANCEL, STC_RSP_OK, 0);
		`CHK("cancel", 7'h00, {o_do_force_en, o_do_force,
			o_test_active})
		// Stop latch lets go one edge after test mode ends
		@(posedge i_clk);
		#1;
		`CHK("stop clear", 1'b0, o_decel_stop)
		repeat (LOSS + 5) @(posedge i_clk);
		#1;
		`CHK("idle loss", 1'b0, o_decel_stop)
		link(`STC_CMD_MODE, 8'h00, 32'h0000_0003, STC_RSP_BAD_DATA, 0);
		wr(`STC_REG_CTRL, 32'h0000_0005);
		`CHK("base clr", 1'b0, o_base_off)
		// Codes 1 to 3 are reachable only through the mode register
		for (int m = 1; m < 4; m++)
		begin
			wr(`STC_REG_MODE, m);
			link(`STC_CMD_READ_MODE, `STC_NO_MODE_RD, 0, STC_RSP_OK, m);
		end
		wr(`STC_REG_MODE, 0);
		$display("test loss stop and cancel done");
		// Lowest and highest table index, every field
		for (int f = 0; f < 4; f++)
		begin
			wr(10'h210 | 10'(f << 2), 32'hA100_0000 + f);
			wr(10'h3F0 | 10'(f << 2), 32'h5F00_0000 + f);
		end
		for (int f = 0; f < 4; f++)
		begin
			link(tcmd[f], 8'h01, 0, STC_RSP_OK, 32'hA100_0000 + f);
			link(tcmd[f], 8'h1F, 0, STC_RSP_OK, 32'h5F00_0000 + f);
			link(tcmd[f], 8'h00, 0, STC_RSP_BAD_NO, 0);
			link(tcmd[f], 8'h20, 0, STC_RSP_BAD_NO, 0);
		end
		rd(10'h0FC, d);
		`CHK("unmapped", 32'h0000_0000, d)
		$display("test point table done");
		end_of_test();
	end
endmodule : stc_handler_tb_top
